// ==== rtl/pcc_pkg.sv ====
// Purpose: constants for the loop-cap and second-synth control block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: register indices are kept; byte address is four times the index
package pcc_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] PCC_IDX_LF_CAP = 8'h46; // loop_filter_cap_three
	localparam logic [7:0] PCC_IDX_SYNTH2 = 8'h47; // second_synth_control_zero
	localparam logic [9:0] PCC_ADDR_LF_CAP = {PCC_IDX_LF_CAP, 2'h0};
	localparam logic [9:0] PCC_ADDR_SYNTH2 = {PCC_IDX_SYNTH2, 2'h0};
	localparam logic [9:0] PCC_ADDR_STATUS = 10'h200; // status word
	// ==========================================================
	// fields and reset values
	localparam int PCC_CAP_W = 3;
	localparam logic [2:0] PCC_CAP_RST = 3'h0;
	localparam logic [7:0] PCC_CAP_PF_STEP = 8'h05; // pF per code step
	localparam int PCC_POST_LSB = 2;
	localparam logic [2:0] PCC_POST_RST = 3'h7;
	localparam int PCC_RESYNC_BIT = 1;
	localparam logic PCC_RESYNC_RST = 1'b1;
	localparam int PCC_PDN_BIT = 0;
	localparam logic PCC_PDN_RST = 1'b0;
	localparam logic [3:0] PCC_POST_MIN_DIV = 4'h2;
	// ==========================================================
	// timing
	localparam int PCC_CLK_MHZ = 250;
	localparam int PCC_CAL_NS = 400; // calibration run time
	localparam int PCC_CAL_CYC = PCC_CAL_NS * PCC_CLK_MHZ / 1000;
	localparam logic [1:0] PCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] PCC_RESP_SLVERR = 2'h2;
	typedef enum {PCC_CAL_OFF, PCC_CAL_RUN, PCC_CAL_DONE} pcc_cal_type;
endpackage : pcc_pkg

// ==== rtl/pcc_post_div.sv ====
// Purpose: maps the post-divider code to its divide ratio
// Assumes: combinational, code is already registered
// Notes: codes 0 and 1 both give two
`timescale 1ns/1ps
`default_nettype none
module pcc_post_div
	import pcc_pkg::*;
(
	input wire logic [2:0] code_i,
	output logic [3:0] ratio_o
);
	// ==========================================================
	// decode
	wire logic low_code = (code_i < 3'h2); // clamp for 0 and 1
	assign ratio_o = low_code ? PCC_POST_MIN_DIV :
		4'({1'b0, code_i} + 4'h1);
endmodule : pcc_post_div
`default_nettype wire

// ==== rtl/pcc_top.sv ====
// Purpose: loop-cap code and second synthesizer control registers
// Assumes: single clock, AXI4-Lite slave, one access of each kind at once
// Notes: synth enable and calibration run are outputs to analog logic
// Overview of operation
// - three-bit cap code, reset zero, 5pF steps
// - post-divider field bits 4:2, reset seven
// - codes 0,1 divide two; 2..7 three..eight
// - resync bit gates SYNC to synth channels
// - powerdown bit gates enable and calibrate after reset
// - powerdown set disables synth, resets calibration
// - powerdown clear re-enables, restarts calibration
`timescale 1ns/1ps
`default_nettype none
module pcc_top
	import pcc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [9:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [9:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sync_i,
	output logic [2:0] loop_filter_cap_three_code_o,
	output logic [7:0] cap_pf_o,
	output logic [3:0] post_ratio_o,
	output logic synth_enable_o,
	output logic cal_reset_o,
	output logic cal_start_o,
	output logic synth_resync_o
);
	// ==========================================================
	// register state
	logic [2:0] cap_q; // loop filter cap code
	logic [2:0] post_q; // post-divider code
	logic resync_q; // resync enable
	logic pdn_q; // power-down
	logic pdn_prev_q; // last cycle's power-down
	logic boot_q; // high once reset released
	pcc_cal_type cal_q; // calibration state
	logic [15:0] cal_cnt_q; // calibration run counter
	// write channel holding
	logic aw_have_q;
	logic w_have_q;
	logic [9:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [3:0] ratio_q;
	logic en_q;
	logic calrst_q;
	logic calst_q;
	logic resync_out_q;
	logic aw_rdy_q; // write address ready, decided one edge ahead
	logic w_rdy_q; // write data ready
	logic ar_rdy_q; // read address ready
	logic [7:0] cap_pf_q; // capacitance in pF, kept beside the code

	// ==========================================================
	// write path decode
	wire logic aw_take = s_axi_awvalid && aw_rdy_q;
	wire logic w_take = s_axi_wvalid && w_rdy_q;
	wire logic wr_go = aw_have_q && w_have_q && !bvalid_q;
	wire logic wr_cap = wr_go && aw_addr_q == PCC_ADDR_LF_CAP;
	wire logic wr_syn = wr_go && aw_addr_q == PCC_ADDR_SYNTH2;
	wire logic wr_ok = wr_cap || wr_syn;
	wire logic lane0 = w_strb_q[0]; // fields live in byte 0 only
	// reserved bits are held in w_data_q but never reach a config flop
	wire logic [2:0] cap_d = (wr_cap && lane0) ?
		w_data_q[2:0] : cap_q;
	wire logic [2:0] post_d = (wr_syn && lane0) ?
		w_data_q[PCC_POST_LSB +: 3] : post_q;
	wire logic resync_d = (wr_syn && lane0) ?
		w_data_q[PCC_RESYNC_BIT] : resync_q;
	wire logic pdn_d = (wr_syn && lane0) ?
		w_data_q[PCC_PDN_BIT] : pdn_q;

	// ==========================================================
	// read path decode
	wire logic ar_take = s_axi_arvalid && ar_rdy_q;
	wire logic [31:0] rd_cap = {29'h0, cap_q};
	wire logic [31:0] rd_syn = {27'h0, post_q, resync_q, pdn_q};
	wire logic [31:0] rd_sts = {28'h0, ratio_q == 4'h0 ? 1'b0 : 1'b1,
		cal_q == PCC_CAL_DONE, cal_q == PCC_CAL_RUN, en_q};
	wire logic rd_hit_cap = s_axi_araddr == PCC_ADDR_LF_CAP;
	wire logic rd_hit_syn = s_axi_araddr == PCC_ADDR_SYNTH2;
	wire logic rd_hit_sts = s_axi_araddr == PCC_ADDR_STATUS;
	wire logic rd_hit = rd_hit_cap || rd_hit_syn || rd_hit_sts;
	wire logic [31:0] rd_word = rd_hit_cap ? rd_cap :
		rd_hit_syn ? rd_syn : rd_hit_sts ? rd_sts : 32'h0;

	// ==========================================================
	// channel state one edge ahead
	// readies are flops, so they must see the state they will guard
	wire logic aw_have_d = !wr_go && (aw_have_q || aw_take);
	wire logic w_have_d = !wr_go && (w_have_q || w_take);
	wire logic bvalid_d = wr_go || (bvalid_q && !s_axi_bready);
	wire logic rvalid_d = ar_take || (rvalid_q && !s_axi_rready);

	// ==========================================================
	// calibration control
	// power-down rising resets calibration, falling restarts it
	wire logic pdn_fall = pdn_prev_q && !pdn_q;
	wire logic cal_kick = (!boot_q && !pdn_q) || pdn_fall;
	wire logic cal_end = cal_q == PCC_CAL_RUN &&
		cal_cnt_q == 16'(PCC_CAL_CYC - 1);
	wire logic [3:0] ratio_w;

	pcc_post_div u_post (
		.code_i(post_q),
		.ratio_o(ratio_w)
	);

	// ==========================================================
	// axi write handshake flops
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 10'h000;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= PCC_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin // both halves present: answer
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? PCC_RESP_OKAY : PCC_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// axi read flops
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= PCC_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_hit ? PCC_RESP_OKAY : PCC_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// ready flops
	// closed during reset; they open one edge after release
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_rdy_q <= 1'b0;
			w_rdy_q <= 1'b0;
			ar_rdy_q <= 1'b0;
		end else begin
			aw_rdy_q <= !aw_have_d && !bvalid_d; // one address held
			w_rdy_q <= !w_have_d && !bvalid_d; // one data word held
			ar_rdy_q <= !rvalid_d; // one read under way
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cap_q <= PCC_CAP_RST;
			cap_pf_q <= 8'h00;
			post_q <= PCC_POST_RST;
			resync_q <= PCC_RESYNC_RST;
			pdn_q <= PCC_PDN_RST;
			pdn_prev_q <= PCC_PDN_RST;
		end else begin
			cap_q <= cap_d;
			cap_pf_q <= 8'(cap_d * PCC_CAP_PF_STEP);
			post_q <= post_d;
			resync_q <= resync_d;
			pdn_q <= pdn_d;
			pdn_prev_q <= pdn_q;
		end
	end

	// ==========================================================
	// calibration sequencer
	// runs once after reset release unless powered down
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			boot_q <= 1'b0;
			cal_q <= PCC_CAL_OFF;
			cal_cnt_q <= 16'h0000;
		end else begin
			boot_q <= 1'b1;
			if (pdn_q) begin // held in reset while down
				cal_q <= PCC_CAL_OFF;
				cal_cnt_q <= 16'h0000;
			end else if (cal_kick) begin
				cal_q <= PCC_CAL_RUN;
				cal_cnt_q <= 16'h0000;
			end else begin
				case (cal_q)
					PCC_CAL_RUN: begin
						cal_cnt_q <= cal_cnt_q + 16'h0001;
						if (cal_end) begin
							cal_q <= PCC_CAL_DONE;
						end
					end
					PCC_CAL_DONE: cal_q <= PCC_CAL_DONE;
					PCC_CAL_OFF: cal_q <= PCC_CAL_OFF;
					default: cal_q <= PCC_CAL_OFF;
				endcase
			end
		end
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ratio_q <= 4'h0;
			en_q <= 1'b0;
			calrst_q <= 1'b1;
			calst_q <= 1'b0;
			resync_out_q <= 1'b0;
		end else begin
			ratio_q <= ratio_w;
			en_q <= !pdn_q;
			calrst_q <= pdn_q;
			calst_q <= cal_kick && !pdn_q;
			resync_out_q <= sync_i && resync_q;
		end
	end

	assign s_axi_awready = aw_rdy_q;
	assign s_axi_wready = w_rdy_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ar_rdy_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign loop_filter_cap_three_code_o = cap_q;
	// capacitance in pF, five per code step
	assign cap_pf_o = cap_pf_q;
	assign post_ratio_o = ratio_q;
	assign synth_enable_o = en_q;
	assign cal_reset_o = calrst_q;
	assign cal_start_o = calst_q;
	assign synth_resync_o = resync_out_q;

	// ==========================================================
	// checks
	sequence s_pdn_rise;
		!pdn_q ##1 pdn_q;
	endsequence
	sequence s_pdn_drop;
		pdn_q ##1 !pdn_q;
	endsequence
	a_cap_reads_back: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wr_cap && lane0 |=> cap_q == $past(w_data_q[2:0]))
		else $error("cap code not stored");
	a_post_stores: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wr_syn && lane0 |=> post_q == $past(w_data_q[4:2]))
		else $error("post code not stored");
	a_ratio_map: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		boot_q |=> ratio_q == (($past(post_q) < 3'h2) ? 4'h2 :
		4'($past(post_q)) + 4'h1))
		else $error("post ratio wrong");
	a_resync_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		sync_i && !resync_q |=> !synth_resync_o)
		else $error("sync passed while disabled");
	a_enable_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_pdn_rise |=> !synth_enable_o && cal_q == PCC_CAL_OFF)
		else $error("synth not disabled");
	a_cal_restart: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_pdn_drop |=> cal_q == PCC_CAL_RUN ##0 cal_start_o)
		else $error("calibration not restarted");
	a_boot_cal: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rst_b_i && !boot_q && !pdn_q |=> cal_q == PCC_CAL_RUN)
		else $error("no calibration after reset");
	a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rvalid_q |-> rdata_q[31:5] == 27'h0)
		else $error("reserved bits nonzero");
endmodule : pcc_top
`default_nettype wire

// ==== dv/pcc_top_bench.sv ====
// Purpose: self-checking bench for the loop-cap and synth control block
// Assumes: AXI4-Lite master tasks, bready and rready held high throughout
// Notes: register effects are checked after a read-back, resync-off after the write response; never same edge
`timescale 1ns/1ps
`default_nettype none
module pcc_top_bench
	import pcc_pkg::*;
;
	// ==========================================================
	// stimulus and observed signals
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [9:0] aw_a = 10'h000, ar_a = 10'h000;
	logic aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0, sync = 1'b0;
	logic [31:0] w_d = 32'h00000000;
	logic [3:0] w_s = 4'h0;
	logic awrdy, wrdy, bvld, arrdy, rvld, en, calr, cals, rsy;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdat, d;
	logic [2:0] code;
	logic [7:0] pf;
	logic [3:0] ratio;
	int fail_count = 0, compares = 0, cyc = 0, starts = 0, s0;
	// ==========================================================
	// device under test
	pcc_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(aw_a),
		.s_axi_awvalid(aw_v), .s_axi_awready(awrdy), .s_axi_wdata(w_d),
		.s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvld), .s_axi_bready(1'b1),
		.s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(arrdy),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rvld),
		.s_axi_rready(1'b1), .sync_i(sync), .loop_filter_cap_three_code_o(code),
		.cap_pf_o(pf), .post_ratio_o(ratio), .synth_enable_o(en),
		.cal_reset_o(calr), .cal_start_o(cals), .synth_resync_o(rsy));
	// 4 ns period clock
	always #2 clk_i = ~clk_i;
	// counts calibration starts and cuts a hang short
	always @(posedge clk_i) begin
		cyc++;
		if (rst_b_i && cals === 1'b1) begin
			starts++;
		end
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end
	// ==========================================================
	// bus tasks; ready is sampled at the edge, release follows it
	task automatic axw(input logic [9:0] a, input logic [31:0] v,
		input logic [3:0] s, output logic [1:0] rs);
		logic aok, wok;
		aok = 1'b0;
		wok = 1'b0;
		aw_a <= a;
		w_d <= v;
		w_s <= s;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		while (!(aok && wok)) begin
			@(posedge clk_i);
			if (!aok && awrdy === 1'b1) begin
				aok = 1'b1;
				aw_v <= 1'b0;
			end
			if (!wok && wrdy === 1'b1) begin
				wok = 1'b1;
				w_v <= 1'b0;
			end
		end
		do @(posedge clk_i); while (bvld !== 1'b1);
		rs = bresp;
	endtask : axw
	task automatic axr(input logic [9:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		ar_a <= a;
		ar_v <= 1'b1;
		do @(posedge clk_i); while (arrdy !== 1'b1);
		ar_v <= 1'b0;
		do @(posedge clk_i); while (rvld !== 1'b1);
		v = rdat;
		rs = rresp;
	endtask : axr
	// one comparison, reported on mismatch
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// one sync pulse; resync output stands one cycle, seen an edge later
	task automatic pulse(input logic e);
		sync <= 1'b1;
		@(posedge clk_i);
		sync <= 1'b0;
		@(posedge clk_i);
		chk(32'(rsy), 32'(e));
		@(posedge clk_i);
		chk(32'(rsy), 32'h0);
	endtask : pulse
	task automatic results();
		if (fail_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(32'(starts), 32'h1);
		chk({calr, en}, 32'h1);
		axr(PCC_ADDR_LF_CAP, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(PCC_RESP_OKAY));
		axr(PCC_ADDR_SYNTH2, d, r);
		chk(d, 32'h1E);
		chk(32'(ratio), 32'h8);
		// every cap code, with reserved bits written high
		for (int c = 0; c < 8; c++) begin
			axw(PCC_ADDR_LF_CAP, 32'hFFFFFFF8 | c, 4'hF, r);
			chk(32'(r), 32'(PCC_RESP_OKAY));
			axr(PCC_ADDR_LF_CAP, d, r);
			chk(d, 32'(c));
			chk({code, pf}, {3'(c), 8'(c * 5)});
		end
		// strobe low leaves the cap code alone
		axw(PCC_ADDR_LF_CAP, 32'h2, 4'h0, r);
		axr(PCC_ADDR_LF_CAP, d, r);
		chk(d, 32'h7);
		// every post-divider code, resync on, reserved bits high
		for (int p = 0; p < 8; p++) begin
			axw(PCC_ADDR_SYNTH2, 32'hFFFFFFE2 | (p << 2), 4'hF, r);
			axr(PCC_ADDR_SYNTH2, d, r);
			chk(d, 32'h2 | (p << 2));
			chk(32'(ratio), (p < 2) ? 32'h2 : 32'(p + 1));
		end
		pulse(1'b1);
		axw(PCC_ADDR_SYNTH2, 32'h1C, 4'hF, r);
		pulse(1'b0);
		// powerdown: status shows only the ratio as valid
		s0 = starts;
		axw(PCC_ADDR_SYNTH2, 32'h1F, 4'hF, r);
		axr(PCC_ADDR_STATUS, d, r);
		chk({calr, en}, 32'h2);
		chk(d, 32'h8);
		// wake-up: calibration runs again, then completes
		axw(PCC_ADDR_SYNTH2, 32'h1E, 4'hF, r);
		axr(PCC_ADDR_STATUS, d, r);
		chk({calr, en}, 32'h1);
		chk(32'(starts), 32'(s0 + 1));
		chk(d, 32'hB);
		repeat (110) @(posedge clk_i); // calibration lasts 100 cycles
		axr(PCC_ADDR_STATUS, d, r);
		chk(d, 32'hD);
		// unmapped places answer with an error and read zero
		axr(10'h004, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(PCC_RESP_SLVERR));
		axw(10'h004, 32'hFF, 4'hF, r);
		chk(32'(r), 32'(PCC_RESP_SLVERR));
		results();
	end
endmodule : pcc_top_bench
`default_nettype wire
